// ---- hw/psr_pkg.sv ----
// protocol-select register bank: shared constants and types
package psr_pkg;

    // ========================================
    // register map and reset values
    localparam int PSR_ADDR_W = 5;
    localparam logic [4:0] PSR_REG_PROTO_CTRL = 5'h01;
    localparam logic [4:0] PSR_REG_TYPEB_TX = 5'h02;
    localparam logic [4:0] PSR_REG_TYPEA_HR = 5'h03;
    localparam logic [7:0] PSR_PROTO_CTRL_RST = 8'h02;
    localparam logic [7:0] PSR_TYPEB_TX_RST = 8'h00;
    localparam logic [7:0] PSR_TYPEA_HR_RST = 8'h00;
    localparam logic [7:0] PSR_UNMAPPED_READ = 8'h00;

    // ========================================
    // protocol control fields
    localparam int PSR_CRC_SKIP_BIT = 7;
    localparam int PSR_DIR_TYPE_BIT = 6;
    localparam int PSR_PROTO_MSB = 4;
    localparam logic [4:0] PSR_PROTO_DEFAULT = 5'h02;
    localparam logic [4:0] PSR_PROTO_VENDOR = 5'h13;

    // ========================================
    // type b transmit framing fields
    localparam int PSR_GUARD_MSB = 7;
    localparam int PSR_GUARD_LSB = 5;
    localparam int PSR_EOF_LEN_BIT = 4;
    localparam int PSR_SOF_HIGH_BIT = 3;
    localparam int PSR_SOF_LOW_BIT = 2;
    localparam int PSR_GUARD_EACH_BIT = 1;
    localparam logic [3:0] PSR_LOW_LONG_ETU = 4'hB;
    localparam logic [3:0] PSR_LOW_SHORT_ETU = 4'hA;
    localparam logic [1:0] PSR_HIGH_LONG_ETU = 2'h3;
    localparam logic [1:0] PSR_HIGH_SHORT_ETU = 2'h2;

    // ========================================
    // type a high-rate option fields
    localparam int PSR_DIF_RATE_BIT = 7;
    localparam int PSR_TX_RATE_MSB = 6;
    localparam int PSR_TX_RATE_LSB = 5;

    // protocol families; rate code 0..3 = 106, 212, 424, 848 kbps
    typedef enum logic [2:0] {
        PSR_FAM_VIC_SINGLE,
        PSR_FAM_VIC_DOUBLE,
        PSR_FAM_TYPE_A,
        PSR_FAM_TYPE_B,
        PSR_FAM_VENDOR,
        PSR_FAM_RESERVED
    } psr_family_e;

endpackage

// ---- hw/psr_cfg_if.sv ----
// carrier between register bank and protocol decoder
`timescale 1ns/100ps
interface psr_cfg_if;
    import psr_pkg::*;
    logic [4:0] proto_code;
    logic [7:0] typea_opts;
    psr_family_e family;
    logic coding_256;
    logic high_rate;
    logic [1:0] rx_rate;
    logic [1:0] tx_rate;

    modport dec
    (
        input proto_code, typea_opts,
        output family, coding_256, high_rate, rx_rate, tx_rate
    );
    modport bank
    (
        output proto_code, typea_opts,
        input family, coding_256, high_rate, rx_rate, tx_rate
    );
endinterface

// ---- hw/psr_proto_decode.sv ----
// protocol code decoder with registered results
`timescale 1ns/100ps
module psr_proto_decode
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    psr_cfg_if.dec cfg
);
    import psr_pkg::*;

    psr_family_e next_family;
    logic next_coding_256;
    logic next_high_rate;
    logic [1:0] next_rx_rate;
    logic [1:0] next_tx_rate;

    // ========================================
    // family lookup from the upper code bits
    function automatic psr_family_e fam_of(input logic [4:0] code);
        psr_family_e f;
        f = PSR_FAM_RESERVED;
        case (code[4:2])
            3'h0: f = PSR_FAM_VIC_SINGLE;
            3'h1: f = PSR_FAM_VIC_DOUBLE;
            3'h2: f = PSR_FAM_TYPE_A;
            3'h3: f = PSR_FAM_TYPE_B;
            default: f = (code == PSR_PROTO_VENDOR) ? PSR_FAM_VENDOR
                                                    : PSR_FAM_RESERVED;
        endcase
        return f;
    endfunction

    // decode next values; reserved codes decode to a harmless family
    always_comb
    begin
        next_family = fam_of(cfg.proto_code);
        // low bit coding, bit 1 rate
        next_coding_256 = cfg.proto_code[0];
        next_high_rate = cfg.proto_code[1];
        // type a/b rate from low bits
        next_rx_rate = cfg.proto_code[1:0];
        if (cfg.typea_opts[PSR_DIF_RATE_BIT])
        begin
            next_tx_rate = cfg.typea_opts[PSR_TX_RATE_MSB:PSR_TX_RATE_LSB];
        end
        else
        begin
            next_tx_rate = cfg.proto_code[1:0];
        end
    end

    // register results so consumers see glitch-free levels
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            // reset decode matches the default code, no glitch on release
            cfg.family <= fam_of(PSR_PROTO_DEFAULT);
            cfg.coding_256 <= PSR_PROTO_DEFAULT[0];
            cfg.high_rate <= PSR_PROTO_DEFAULT[1];
            cfg.rx_rate <= PSR_PROTO_DEFAULT[1:0];
            cfg.tx_rate <= PSR_PROTO_DEFAULT[1:0];
        end
        else
        begin
            cfg.family <= next_family;
            cfg.coding_256 <= next_coding_256;
            cfg.high_rate <= next_high_rate;
            cfg.rx_rate <= next_rx_rate;
            cfg.tx_rate <= next_tx_rate;
        end
    end

    // ========================================
    // checks
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_vic_single_map: assert property (
        cfg.proto_code[4:2] == 3'h0 |=> cfg.family == PSR_FAM_VIC_SINGLE
        && cfg.coding_256 == $past(cfg.proto_code[0])
        && cfg.high_rate == $past(cfg.proto_code[1]))
        else $error("single subcarrier code misdecoded");
    a_vic_double_map: assert property (
        cfg.proto_code[4:2] == 3'h1 |=> cfg.family == PSR_FAM_VIC_DOUBLE)
        else $error("double subcarrier code misdecoded");
    a_typea_map: assert property (
        cfg.proto_code[4:2] == 3'h2 |=> cfg.family == PSR_FAM_TYPE_A
        && cfg.rx_rate == $past(cfg.proto_code[1:0]))
        else $error("type a code misdecoded");
    a_typeb_map: assert property (
        cfg.proto_code[4:2] == 3'h3 |=> cfg.family == PSR_FAM_TYPE_B
        && cfg.rx_rate == $past(cfg.proto_code[1:0]))
        else $error("type b code misdecoded");
    a_tx_rate_split: assert property (
        cfg.typea_opts[PSR_DIF_RATE_BIT] |=>
        cfg.tx_rate == $past(cfg.typea_opts[6:5]))
        else $error("split tx rate not taken from options");
endmodule

// ---- hw/psr_regs.sv ----
// protocol-select and type b framing register bank, top level
// Operation
// - bit 7 set disables receive crc check; clear enables it
// - bit 6 picks raw subcarrier or decoder bit stream and clock
// - codes 0-3 give single subcarrier vicinity, coding and rate bits
// - codes 4-7 give double subcarrier vicinity, coding and rate bits
// - default protocol is code 2, high rate single subcarrier
// - codes 8-11 select type a at 106 to 848 kbps
// - codes 12-15 select type b at 106 to 848 kbps
// - with split rates the code sets receive rate only
// - type b options reset to zero on reset, enable low, control write
// - bits 7..5 give guard etu count between characters
// - bits 4, 2, 3 pick eof low, sof low, sof high lengths
// - bit 1 set keeps guard time after last byte
// - type a options clear on reset, enable low, control write
// - protocol control resets to 0x02
// - control write reloads option registers with their fixed reset values
`timescale 1ns/100ps
module psr_regs
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic enable_i,
    input wire logic [psr_pkg::PSR_ADDR_W-1:0] host_addr_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    output logic [7:0] host_rdata_o,
    output logic preset_load_o,
    output logic rx_crc_check_o,
    output logic direct_bitstream_o,
    output psr_pkg::psr_family_e family_o,
    output logic coding_256_o,
    output logic high_rate_o,
    output logic [1:0] rx_rate_o,
    output logic [1:0] tx_rate_o,
    output logic [2:0] guard_etu_o,
    output logic [3:0] end_frame_low_len_o,
    output logic [3:0] start_frame_low_len_o,
    output logic [1:0] start_frame_high_len_o,
    output logic guard_after_last_o
);
    import psr_pkg::*;

    logic en_meta;
    logic en_sync;
    logic blk_rst;
    logic [7:0] proto_ctrl;
    logic [7:0] typeb_opts;
    logic [7:0] typea_opts;
    logic [7:0] next_proto_ctrl;
    logic [7:0] next_typeb_opts;
    logic [7:0] next_typea_opts;
    logic [7:0] next_rdata;
    logic next_preset_load;
    logic wr_proto;

    psr_cfg_if cfg ();

    // ========================================
    // enable pin synchroniser; low enable holds the bank in reset
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end
        else
        begin
            en_meta <= enable_i;
            en_sync <= en_meta;
        end
    end

    assign blk_rst = srst_i || !en_sync;
    assign wr_proto = host_wr_i && (host_addr_i == PSR_REG_PROTO_CTRL);

    // ========================================
    // register write and preset reload
    always_comb
    begin
        next_proto_ctrl = proto_ctrl;
        next_typeb_opts = typeb_opts;
        next_typea_opts = typea_opts;
        next_preset_load = 1'b0;
        if (wr_proto)
        begin
            next_proto_ctrl = host_wdata_i;
            next_typeb_opts = PSR_TYPEB_TX_RST;
            next_preset_load = 1'b1;
            next_typea_opts = PSR_TYPEA_HR_RST;
        end
        else if (host_wr_i && host_addr_i == PSR_REG_TYPEB_TX)
        begin
            next_typeb_opts = host_wdata_i;
        end
        else if (host_wr_i && host_addr_i == PSR_REG_TYPEA_HR)
        begin
            next_typea_opts = host_wdata_i;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb
    begin
        next_rdata = host_rdata_o;
        if (host_rd_i)
        begin
            case (host_addr_i)
                PSR_REG_PROTO_CTRL: next_rdata = proto_ctrl;
                PSR_REG_TYPEB_TX: next_rdata = typeb_opts;
                PSR_REG_TYPEA_HR: next_rdata = typea_opts;
                default: next_rdata = PSR_UNMAPPED_READ;
            endcase
        end
    end

    // register state; control and framing outputs are registered below from the same next values
    always_ff @(posedge core_clk_i)
    begin
        if (blk_rst)
        begin
            proto_ctrl <= PSR_PROTO_CTRL_RST;
            typeb_opts <= PSR_TYPEB_TX_RST;
            typea_opts <= PSR_TYPEA_HR_RST;
            host_rdata_o <= 8'h00;
            preset_load_o <= 1'b0;
        end
        else
        begin
            proto_ctrl <= next_proto_ctrl;
            typeb_opts <= next_typeb_opts;
            typea_opts <= next_typea_opts;
            host_rdata_o <= next_rdata;
            preset_load_o <= next_preset_load;
        end
    end

    // ========================================
    // configuration outputs, registered from next values
    always_ff @(posedge core_clk_i)
    begin
        if (blk_rst)
        begin
            rx_crc_check_o <= !PSR_PROTO_CTRL_RST[PSR_CRC_SKIP_BIT];
            direct_bitstream_o <= PSR_PROTO_CTRL_RST[PSR_DIR_TYPE_BIT];
            guard_etu_o <= PSR_TYPEB_TX_RST[PSR_GUARD_MSB:PSR_GUARD_LSB];
            end_frame_low_len_o <= PSR_LOW_SHORT_ETU;
            start_frame_low_len_o <= PSR_LOW_SHORT_ETU;
            start_frame_high_len_o <= PSR_HIGH_SHORT_ETU;
            guard_after_last_o <= PSR_TYPEB_TX_RST[PSR_GUARD_EACH_BIT];
        end
        else
        begin
            // crc check unless skip bit set
            rx_crc_check_o <= !next_proto_ctrl[PSR_CRC_SKIP_BIT];
            direct_bitstream_o <= next_proto_ctrl[PSR_DIR_TYPE_BIT];
            guard_etu_o <= next_typeb_opts[PSR_GUARD_MSB:PSR_GUARD_LSB];
            end_frame_low_len_o <= next_typeb_opts[PSR_EOF_LEN_BIT]
                ? PSR_LOW_LONG_ETU : PSR_LOW_SHORT_ETU;
            start_frame_low_len_o <= next_typeb_opts[PSR_SOF_LOW_BIT]
                ? PSR_LOW_LONG_ETU : PSR_LOW_SHORT_ETU;
            start_frame_high_len_o <= next_typeb_opts[PSR_SOF_HIGH_BIT]
                ? PSR_HIGH_LONG_ETU : PSR_HIGH_SHORT_ETU;
            guard_after_last_o <= next_typeb_opts[PSR_GUARD_EACH_BIT];
        end
    end

    // ========================================
    // protocol decoding, one cycle behind the register
    assign cfg.proto_code = proto_ctrl[PSR_PROTO_MSB:0];
    assign cfg.typea_opts = typea_opts;

    psr_proto_decode psr_proto_decode_inst
    (
        .core_clk_i(core_clk_i),
        .rst_i(blk_rst),
        .cfg(cfg)
    );

    assign family_o = cfg.family;
    assign coding_256_o = cfg.coding_256;
    assign high_rate_o = cfg.high_rate;
    assign rx_rate_o = cfg.rx_rate;
    assign tx_rate_o = cfg.tx_rate;

    // ========================================
    // checks
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (blk_rst);

    a_crc_skip_out: assert property (
        wr_proto |=> rx_crc_check_o == !$past(host_wdata_i[7]))
        else $error("crc check does not follow bit 7");
    a_dir_type_out: assert property (
        wr_proto |=> direct_bitstream_o == $past(host_wdata_i[6]))
        else $error("direct type does not follow bit 6");
    a_default_proto: assert property (
        $past(blk_rst) |-> proto_ctrl == PSR_PROTO_CTRL_RST
        && cfg.proto_code == PSR_PROTO_DEFAULT)
        else $error("protocol control not at default");
    a_default_family: assert property (
        $past(blk_rst) && !wr_proto |=> family_o == PSR_FAM_VIC_SINGLE
        && high_rate_o && !coding_256_o)
        else $error("default protocol misdecoded");
    a_typeb_reset: assert property (
        $past(blk_rst) |-> typeb_opts == PSR_TYPEB_TX_RST)
        else $error("type b options not cleared");
    a_typea_on_ctrl: assert property (
        wr_proto |=> typea_opts == PSR_TYPEA_HR_RST)
        else $error("type a options kept across control write");
    a_preset_pulse: assert property (
        wr_proto |=> preset_load_o ##1 (!preset_load_o || $past(wr_proto)))
        else $error("preset reload pulse wrong");
    a_guard_count: assert property (
        guard_etu_o == typeb_opts[7:5])
        else $error("guard etu count wrong");
    a_frame_lengths: assert property (
        end_frame_low_len_o == (typeb_opts[4] ? 4'hB : 4'hA)
        && start_frame_high_len_o == (typeb_opts[3] ? 2'h3 : 2'h2)
        && start_frame_low_len_o == (typeb_opts[2] ? 4'hB : 4'hA))
        else $error("frame delimiter length wrong");
    a_guard_last: assert property (
        host_wr_i && host_addr_i == PSR_REG_TYPEB_TX |=>
        guard_after_last_o == $past(host_wdata_i[1]))
        else $error("guard after last byte wrong");

    c_proto_write: cover property (wr_proto ##1 preset_load_o);
    c_typeb_write: cover property (
        host_wr_i && host_addr_i == PSR_REG_TYPEB_TX);
    c_split_rate: cover property (
        family_o == PSR_FAM_TYPE_B && tx_rate_o != rx_rate_o);
endmodule

// ---- testbench/psr_regs_tb.sv ----
// self-checking bench for the protocol-select register bank
`timescale 1ns/100ps
module psr_regs_tb;
    import psr_pkg::*;
    // ========================================
    // clock, stimulus and design instance
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic enable_i = 1'b1;
    logic [PSR_ADDR_W-1:0] host_addr_i = '0;
    logic [7:0] host_wdata_i = 8'h00;
    logic host_wr_i = 1'b0;
    logic host_rd_i = 1'b0;
    logic [7:0] host_rdata_o;
    logic preset_load_o, rx_crc_check_o, direct_bitstream_o;
    psr_family_e family_o;
    logic coding_256_o, high_rate_o, guard_after_last_o;
    logic [1:0] rx_rate_o, tx_rate_o, start_frame_high_len_o;
    logic [2:0] guard_etu_o;
    logic [3:0] end_frame_low_len_o, start_frame_low_len_o;
    logic pulse_seen;
    logic [7:0] v;
    logic [4:0] code;
    logic [7:0] frame_tab [5] = '{8'hFE, 8'h00, 8'hA4, 8'h58, 8'h2A};
    int err_total = 0;
    int n_checks = 0;

    // free-running 125 MHz clock
    always #4 core_clk_i = ~core_clk_i;

    psr_regs psr_regs_inst
    (
        .core_clk_i, .srst_i, .enable_i, .host_addr_i, .host_wdata_i,
        .host_wr_i, .host_rd_i, .host_rdata_o, .preset_load_o,
        .rx_crc_check_o, .direct_bitstream_o, .family_o, .coding_256_o,
        .high_rate_o, .rx_rate_o, .tx_rate_o, .guard_etu_o,
        .end_frame_low_len_o, .start_frame_low_len_o,
        .start_frame_high_len_o, .guard_after_last_o
    );

    // ========================================
    // access and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // strobe held one edge; returns once decoded outputs have settled
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        host_addr_i = addr;
        host_wdata_i = data;
        host_wr_i = 1'b1;
        @(negedge core_clk_i);
        host_wr_i = 1'b0;
        pulse_seen = preset_load_o;
        @(negedge core_clk_i);
    endtask

    task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
        host_addr_i = addr;
        host_rd_i = 1'b1;
        @(negedge core_clk_i);
        host_rd_i = 1'b0;
        chk(host_rdata_o, exp);
        @(negedge core_clk_i);
    endtask

    // expected family, worked out from the code table
    function automatic logic [2:0] fam_of(input logic [4:0] c);
        if (c == 5'h13)
            return 3'(PSR_FAM_VENDOR);
        if (c[4])
            return 3'(PSR_FAM_RESERVED);
        case (c[3:2])
            2'h0: return 3'(PSR_FAM_VIC_SINGLE);
            2'h1: return 3'(PSR_FAM_VIC_DOUBLE);
            2'h2: return 3'(PSR_FAM_TYPE_A);
            default: return 3'(PSR_FAM_TYPE_B);
        endcase
    endfunction

    // outputs expected while the bank sits at its reset state
    task automatic chk_default();
        chk({7'h00, rx_crc_check_o}, 8'h01);
        chk({7'h00, direct_bitstream_o}, 8'h00);
        chk({5'h00, family_o}, 8'(PSR_FAM_VIC_SINGLE));
        chk({6'h00, high_rate_o, coding_256_o}, 8'h02);
        chk({6'h00, rx_rate_o}, 8'h02);
        chk({5'h00, guard_etu_o}, 8'h00);
        chk({4'h0, end_frame_low_len_o}, 8'h0A);
        chk({4'h0, start_frame_low_len_o}, 8'h0A);
        chk({6'h00, start_frame_high_len_o}, 8'h02);
    endtask

    // ========================================
    // bounded run time
    initial
    begin
        #400000;
        err_total++;
        close_out();
    end

    // ========================================
    // main sequence
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk_default();
        rd(PSR_REG_PROTO_CTRL, 8'h02);
        rd(PSR_REG_TYPEB_TX, 8'h00);
        rd(PSR_REG_TYPEA_HR, 8'h00);
        // unmapped places read zero, writes there are dropped
        wr(5'h1F, 8'h55);
        rd(5'h1F, PSR_UNMAPPED_READ);
        rd(5'h00, PSR_UNMAPPED_READ);
        rd(PSR_REG_PROTO_CTRL, 8'h02);
        // codes 0 to 15 and 19, crc and direct bits varied
        for (int c = 0; c < 20; c++)
        begin
            // host keeps to listed codes; 16 to 18 are reserved
            if (c > 15 && c < 19)
                continue;
            code = 5'(c);
            v = {code[2], code[0] ^ code[1], 1'b0, code};
            wr(PSR_REG_PROTO_CTRL, v);
            chk({7'h00, pulse_seen}, 8'h01);
            chk({7'h00, rx_crc_check_o}, {7'h00, ~v[7]});
            chk({7'h00, direct_bitstream_o}, {7'h00, v[6]});
            chk({5'h00, family_o}, {5'h00, fam_of(code)});
            chk({7'h00, coding_256_o}, {7'h00, code[0]});
            chk({7'h00, high_rate_o}, {7'h00, code[1]});
            chk({6'h00, rx_rate_o}, {6'h00, code[1:0]});
            chk({6'h00, tx_rate_o}, {6'h00, code[1:0]});
            rd(PSR_REG_PROTO_CTRL, v);
        end
        // framing fields from a table of patterns
        for (int i = 0; i < 5; i++)
        begin
            v = frame_tab[i];
            wr(PSR_REG_TYPEB_TX, v);
            chk({7'h00, pulse_seen}, 8'h00);
            chk({5'h00, guard_etu_o}, {5'h00, v[7:5]});
            chk({4'h0, end_frame_low_len_o}, v[4] ? 8'h0B : 8'h0A);
            chk({6'h00, start_frame_high_len_o}, v[3] ? 8'h03 : 8'h02);
            chk({4'h0, start_frame_low_len_o}, v[2] ? 8'h0B : 8'h0A);
            chk({7'h00, guard_after_last_o}, {7'h00, v[1]});
            rd(PSR_REG_TYPEB_TX, v);
        end
        // split rates: code keeps receive, option sets transmit
        wr(PSR_REG_PROTO_CTRL, 8'h0D);
        wr(PSR_REG_TYPEA_HR, 8'hE0);
        chk({6'h00, rx_rate_o}, 8'h01);
        chk({6'h00, tx_rate_o}, 8'h03);
        rd(PSR_REG_TYPEA_HR, 8'hE0);
        wr(PSR_REG_TYPEA_HR, 8'h20);
        chk({6'h00, tx_rate_o}, 8'h01);
        wr(PSR_REG_TYPEA_HR, 8'hC0);
        wr(PSR_REG_TYPEB_TX, 8'hA4);
        // control write clears the option registers
        wr(PSR_REG_PROTO_CTRL, 8'h0C);
        rd(PSR_REG_TYPEA_HR, 8'h00);
        rd(PSR_REG_TYPEB_TX, PSR_TYPEB_TX_RST);
        chk({6'h00, tx_rate_o}, 8'h00);
        // enable pin low returns bank to reset
        // control first: written last it would clear the options itself
        wr(PSR_REG_PROTO_CTRL, 8'hCF);
        wr(PSR_REG_TYPEB_TX, 8'hFE);
        wr(PSR_REG_TYPEA_HR, 8'hE0);
        enable_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk_default();
        enable_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        rd(PSR_REG_PROTO_CTRL, 8'h02);
        rd(PSR_REG_TYPEB_TX, 8'h00);
        rd(PSR_REG_TYPEA_HR, 8'h00);
        // second synchronous reset in mid-run
        wr(PSR_REG_PROTO_CTRL, 8'hCF);
        wr(PSR_REG_TYPEB_TX, 8'hFE);
        srst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        rd(PSR_REG_TYPEB_TX, 8'h00);
        chk_default();
        close_out();
    end
endmodule
